// ---- plac_pkg.sv ----
package plac_pkg;

  // timing: one two-way sweep takes the free-run period divided by the sweep count
  localparam int unsigned SWEEP_LIMIT     = 8;
  localparam int unsigned FREERUN_SWEEPS  = 8;
  localparam int unsigned FREERUN_MS      = 10000;
  localparam int unsigned CLK_MHZ         = 200;
  localparam longint unsigned SWEEP_CYCLES =
    (longint'(FREERUN_MS) * 1000 * CLK_MHZ) / FREERUN_SWEEPS;
  localparam int unsigned CNT_W           = 32;
  localparam int unsigned SWEEP_W         = 4;
  localparam logic [SWEEP_W-1:0] SWEEP_LAST = 4'(SWEEP_LIMIT - 1);
  localparam int unsigned LOCK_SAMPLES    = 4;

  typedef enum logic [1:0] {
    PLAC_SEL_AUTO,
    PLAC_SEL_FREERUN,
    PLAC_SEL_SEARCH
  } plac_sel_t;

  typedef enum {
    PLAC_ST_SWEEP,
    PLAC_ST_LOCKED,
    PLAC_ST_FREERUN
  } plac_state_t;

  typedef struct packed {
    logic sweepEn;
    logic loopOpen;
    logic biasSel;
    logic lockOk;
  } plac_loop_ctl_t;

endpackage : plac_pkg

// ---- plac_lock_detect.sv ----
`timescale 1ns/1ps
// lock qualifier: detector reports zero phase for several consecutive samples
module plac_lock_detect
  import plac_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic zeroPhase,
  output logic      lockDet
);

  logic [1:0] syncFf;
  logic [2:0] runFf;
  wire        phaseOk = syncFf[1];
  wire        runDone = (runFf == 3'(LOCK_SAMPLES - 1));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syncFf <= 2'h0;
      runFf  <= 3'h0;
      lockDet <= 1'b0;
    end else begin
      syncFf <= {syncFf[0], zeroPhase};
      if (!phaseOk) begin
        runFf   <= 3'h0;
        lockDet <= 1'b0;
      end else if (runDone) begin
        lockDet <= 1'b1;
      end else begin
        runFf <= runFf + 3'h1;
      end
    end
  end

  a_lock_needs_phase: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(lockDet) |-> $past(phaseOk))
    else $error("lock declared without zero phase");

endmodule : plac_lock_detect

// ---- plac_ctrl.sv ----
`timescale 1ns/1ps
// What this block does
// - sweep while searching, drop it on lock
// - at most eight two-way sweeps per attempt
// - then open loop, bias, eight sweep periods
// - partner free-run flag holds loop open
// - otherwise alternate sweep and free-run forever
// - panel selector overrides partner command
// - lock shown on a status output
// - lock means zero phase at detector
module plac_ctrl
  import plac_pkg::*;
#(
  parameter longint unsigned SWEEP_PERIOD = SWEEP_CYCLES
)(
  input  wire logic      mclk,
  input  wire logic      sys_rst,
  input  wire logic      zeroPhase,
  input  wire logic      freeRunCmd,
  input  wire plac_sel_t panelSel,
  output logic           sweepEn,
  output logic           loopOpen,
  output logic           biasSel,
  output logic           lockOk,
  output logic           sweepDir
);

  plac_state_t    stateFf;
  plac_state_t    nxt_state;
  logic [CNT_W-1:0]   halfCntFf;
  logic               dirFf;
  logic [SWEEP_W-1:0] sweepCntFf;
  logic [1:0]         cmdSyncFf;
  logic [1:0]         selSyncA;
  logic [1:0]         selSyncB;
  plac_loop_ctl_t     ctlFf;
  plac_loop_ctl_t     nxt_ctl;
  logic               lockDet;

  plac_lock_detect u_lock (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .zeroPhase (zeroPhase),
    .lockDet   (lockDet)
  );

  // half-period boundaries; a full two-way sweep ends after the down half
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(SWEEP_PERIOD / 2 - 1);
  wire        halfEnd    = (halfCntFf == HALF_LAST);
  wire        sweepEnd   = halfEnd && dirFf;
  wire        groupEnd   = sweepEnd && (sweepCntFf == SWEEP_LAST);
  wire        cmdFree    = cmdSyncFf[1];
  plac_sel_t  selNow;
  assign selNow = plac_sel_t'(selSyncB);
  wire        forceFree  = (selNow == PLAC_SEL_FREERUN);
  wire        forceSrch  = (selNow == PLAC_SEL_SEARCH);
  // panel wins over partner command
  wire        holdOpen   = forceFree || (!forceSrch && cmdFree);

  always_comb begin
    nxt_state = stateFf;
    case (stateFf)
      PLAC_ST_SWEEP: begin
        if (forceFree)
          nxt_state = PLAC_ST_FREERUN;
        else if (lockDet)
          nxt_state = PLAC_ST_LOCKED;
        else if (groupEnd)
          nxt_state = PLAC_ST_FREERUN;
      end
      PLAC_ST_LOCKED: begin
        if (forceFree)
          nxt_state = PLAC_ST_FREERUN;
        else if (!lockDet)
          nxt_state = PLAC_ST_SWEEP;
      end
      PLAC_ST_FREERUN: begin
        if (!holdOpen && (forceSrch || groupEnd))
          nxt_state = PLAC_ST_SWEEP;
      end
      default: nxt_state = PLAC_ST_SWEEP;
    endcase
  end

  always_comb begin
    nxt_ctl.sweepEn  = (nxt_state == PLAC_ST_SWEEP);
    nxt_ctl.loopOpen = (nxt_state == PLAC_ST_FREERUN);
    nxt_ctl.biasSel  = (nxt_state == PLAC_ST_FREERUN);
    nxt_ctl.lockOk   = lockDet;
  end

  wire stateChg = (nxt_state != stateFf);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stateFf    <= PLAC_ST_SWEEP;
      halfCntFf  <= '0;
      dirFf      <= 1'b0;
      sweepCntFf <= '0;
      cmdSyncFf  <= 2'h0;
      selSyncA   <= 2'h0;
      selSyncB   <= 2'h0;
      ctlFf      <= '{sweepEn: 1'b1, default: 1'b0};
    end else begin
      cmdSyncFf <= {cmdSyncFf[0], freeRunCmd};
      selSyncA  <= panelSel;
      selSyncB  <= selSyncA;
      stateFf   <= nxt_state;
      ctlFf     <= nxt_ctl;
      // same timebase paces sweeps and free-run so both periods match
      if (stateChg || halfEnd)
        halfCntFf <= '0;
      else
        halfCntFf <= halfCntFf + 1'b1;
      if (stateChg)
        dirFf <= 1'b0;
      else if (halfEnd)
        dirFf <= ~dirFf;
      // a held free-run parks on its last sweep, so release resumes within one sweep
      if (stateChg)
        sweepCntFf <= '0;
      else if (sweepEnd && !(groupEnd && stateFf == PLAC_ST_FREERUN))
        sweepCntFf <= sweepCntFf + 1'b1;
    end
  end

  assign sweepEn  = ctlFf.sweepEn;
  assign loopOpen = ctlFf.loopOpen;
  assign biasSel  = ctlFf.biasSel;
  assign lockOk   = ctlFf.lockOk;
  assign sweepDir = dirFf;

  sequence s_group_done;
    (stateFf == PLAC_ST_SWEEP) && groupEnd && !lockDet && !forceFree;
  endsequence

  a_sweep_drops_lock: assert property (@(posedge mclk) disable iff (sys_rst)
    (stateFf == PLAC_ST_SWEEP && lockDet && !forceFree) |=> !sweepEn)
    else $error("sweep still applied after lock");

  // direction flips only on half boundaries or clears on a state change, so each sweep is two equal halves
  a_dir_hold_half: assert property (@(posedge mclk) disable iff (sys_rst)
    (!stateChg && !halfEnd) |=> $stable(sweepDir))
    else $error("sweep direction changed inside a half");

  a_dir_flip_half: assert property (@(posedge mclk) disable iff (sys_rst)
    (!stateChg && halfEnd) |=> (sweepDir != $past(sweepDir)))
    else $error("sweep direction missed its flip");

  a_bias_with_open: assert property (@(posedge mclk) disable iff (sys_rst)
    (biasSel == loopOpen) && !(loopOpen && sweepEn))
    else $error("bias and loop switch disagree");

  a_sweep_count_cap: assert property (@(posedge mclk) disable iff (sys_rst)
    (stateFf == PLAC_ST_SWEEP) |-> (sweepCntFf <= SWEEP_LAST))
    else $error("more than eight sweeps in one attempt");

  a_freerun_after_group: assert property (@(posedge mclk) disable iff (sys_rst)
    s_group_done |=> (loopOpen && biasSel && !sweepEn))
    else $error("loop not opened after sweep group");

  a_hold_open_cmd: assert property (@(posedge mclk) disable iff (sys_rst)
    (stateFf == PLAC_ST_FREERUN && holdOpen) |=> loopOpen)
    else $error("loop closed while free-run held");

  a_resume_search: assert property (@(posedge mclk) disable iff (sys_rst)
    (stateFf == PLAC_ST_FREERUN && groupEnd && !holdOpen) |=> sweepEn)
    else $error("search did not resume");

  a_panel_priority: assert property (@(posedge mclk) disable iff (sys_rst)
    forceFree [*2] |=> loopOpen)
    else $error("panel free-run not obeyed");

  a_lock_status: assert property (@(posedge mclk) disable iff (sys_rst)
    lockOk == $past(lockDet))
    else $error("lock status mismatch");

  a_relock_restart: assert property (@(posedge mclk) disable iff (sys_rst)
    (stateFf == PLAC_ST_LOCKED && !lockDet && !forceFree) |=> (sweepEn && sweepCntFf == '0))
    else $error("lost lock did not restart sweep");

endmodule : plac_ctrl

// ---- plac_support_model.sv ----
`timescale 1ns/1ps
module plac_support_model #(
  parameter int HOLD = 300
)(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic cmdPulse,
  output logic      freeRunCmd
);
  int cnt_ff;
  // flag self-clears so a silent host cannot pin the loop open
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      freeRunCmd <= 1'b0;
      cnt_ff     <= 0;
    end else if (cmdPulse) begin
      freeRunCmd <= 1'b1;
      cnt_ff     <= HOLD;
    end else if (cnt_ff == 1) begin
      freeRunCmd <= 1'b0;
      cnt_ff     <= 0;
    end else if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
endmodule : plac_support_model

// ---- plac_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module plac_ctrl_tb_top;
  import plac_pkg::*;
  logic      mclk;
  logic      sys_rst;
  logic      zeroPhase;
  logic      cmdPulse;
  logic      freeRunCmd;
  logic      sweepEn;
  logic      loopOpen;
  logic      biasSel;
  logic      lockOk;
  logic      sweepDir;
  plac_sel_t panelSel;
  int        errors;
  int        compares;
  localparam plac_loop_ctl_t SWP = 4'h8;
  localparam plac_loop_ctl_t OPN = 4'h6;
  localparam plac_loop_ctl_t LCK = 4'h1;
  plac_loop_ctl_t ctl;
  assign ctl = {sweepEn, loopOpen, biasSel, lockOk};

  // short sweep keeps each attempt at 160 cycles
  plac_ctrl #(.SWEEP_PERIOD(20)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .zeroPhase(zeroPhase), .freeRunCmd(freeRunCmd),
    .panelSel(panelSel), .sweepEn(sweepEn), .loopOpen(loopOpen), .biasSel(biasSel),
    .lockOk(lockOk), .sweepDir(sweepDir)
  );
  plac_support_model #(.HOLD(300)) partner (
    .mclk(mclk), .sys_rst(sys_rst), .cmdPulse(cmdPulse), .freeRunCmd(freeRunCmd)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic expectHold(input int n, input plac_loop_ctl_t exp);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      compares++;
      if (ctl !== exp) begin
        errors++;
        $display("[FAIL] %0t ctl %h not held at %h", $time, ctl, exp);
        break;
      end
    end
  endtask : expectHold

  task automatic expectDir(input logic exp);
    compares++;
    if (sweepDir !== exp) begin
      errors++;
      $display("[FAIL] %0t sweepDir %b expected %b", $time, sweepDir, exp);
    end
  endtask : expectDir

  task automatic expectWithin(input int n, input plac_loop_ctl_t exp);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      if (ctl === exp) begin
        compares++;
        return;
      end
    end
    errors++;
    $display("[FAIL] %0t ctl %h never reached %h", $time, ctl, exp);
    complete_run();
  endtask : expectWithin

  initial begin
    sys_rst   = 1'b1;
    zeroPhase = 1'b0;
    cmdPulse  = 1'b0;
    panelSel  = PLAC_SEL_AUTO;
    errors    = 0;
    compares  = 0;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    expectHold(9, SWP);
    expectDir(1'b0);
    expectHold(1, SWP);
    expectDir(1'b1);
    expectHold(149, SWP);
    expectHold(120, OPN);
    cmdPulse = 1'b1;
    @(negedge mclk);
    cmdPulse = 1'b0;
    expectHold(250, OPN);
    expectWithin(250, SWP);
    expectWithin(200, OPN);
    panelSel = PLAC_SEL_SEARCH;
    expectWithin(8, SWP);
    panelSel = PLAC_SEL_FREERUN;
    expectWithin(8, OPN);
    expectHold(200, OPN);
    panelSel  = PLAC_SEL_SEARCH;
    zeroPhase = 1'b1;
    expectWithin(16, LCK);
    panelSel = PLAC_SEL_AUTO;
    expectHold(20, LCK);
    zeroPhase = 1'b0;
    expectWithin(8, SWP);
    complete_run();
  end
endmodule : plac_ctrl_tb_top
